// [hw/rsp_pkg.sv]
// package for the receiver status-pin and start-up block
// assumes one system clock domain; link-side clocks are sampled, not used as clocks
package rsp_pkg;
  // ************************************************
  // register map (apb byte addresses)
  // ************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
  localparam logic [7:0] ADDR_ID = 8'h14;
  // ************************************************
  // field positions
  // ************************************************
  localparam int CTRL_RUN_BIT = 0;
  localparam int ID_REV_LSB = 0;
  localparam int ID_DEV_LSB = 4;
  localparam int IRQ_NO_VALIDITY_ERROR_OUT_BIT = 0;
  localparam int IRQ_LOCK_BIT = 1;
  localparam int IRQ_OUTEN_BIT = 2;
  localparam int IRQ_W = 3;
  // ************************************************
  // identity (arbitrary values) and reset values
  // ************************************************
  localparam logic [3:0] DEV_ID_CODE = 4'hA;
  localparam logic [3:0] REV_CODE = 4'h1;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
  // ************************************************
  // timing
  // ************************************************
  localparam int CLK_MHZ = 250;
  localparam int SETTLE_US = 100;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  typedef enum logic [1:0] {ST_RESET, ST_IDLE, ST_SETTLE, ST_RUN} rsp_state_t;
endpackage

// [hw/rsp_top.sv]
// status pins, serial C/U outputs, output clocks and start-up sequence of a biphase receiver
// assumes decoded frame events arrive synchronous to i_sys_clk; pins are synchronised here
//
// Behaviour
// - no_validity_error_out high on parity, biphase or lock loss
// - word clock toggles once per slot, one period per sample pair
// - bit clock times data, direction by role
// - in hardware mode, serial data pin level selects master/slave
// - audio flag output, low means audio
// - mode input picks software or hardware control
// - user bit shifted on each word-clock edge
// - status bit shifted on each word-clock edge
// - original flag from category and L bit
// - in hardware mode, original and emphasis pins select format
// - reset clears state and mutes outputs
// - host loads settings then sets run
// - serial outputs wait for settled pll
// - option pins inputs in reset, latched after
// - software mode: emphasis pin gives address bit
// - readable fixed four-bit device code
// - readable four-bit revision code
// - emphasis low only for 50/15 us
`timescale 1ns/1ps
module rsp_top #(
  parameter int SETTLE_CYCLES = rsp_pkg::SETTLE_CYC,
  parameter int BCLK_DIV = 4,
  parameter int SLOT_BITS = 32
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_frame_stb,
  input wire logic i_parity_err,
  input wire logic i_biphase_err,
  input wire logic i_pll_lock,
  input wire logic i_cs_bit,
  input wire logic i_user_bit,
  input wire logic i_cs_audio,
  input wire logic i_cs_l_bit,
  input wire logic [7:0] i_cs_category,
  input wire logic [2:0] i_cs_preemphasis_flag,
  input wire logic [23:0] i_sample,
  input wire logic i_mode_hw,
  input wire logic i_serial_audio_out_pin,
  input wire logic i_original_source_flag_pin,
  input wire logic i_preemphasis_flag_pin,
  input wire logic i_bclk_pin,
  input wire logic i_wclk_pin,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_irq,
  output logic o_no_validity_error_out,
  output logic o_serial_audio_out,
  output logic o_serial_audio_oe,
  output logic o_out_bit_clock,
  output logic o_out_bit_clock_oe,
  output logic o_out_word_clock,
  output logic o_out_word_clock_oe,
  output logic o_audio_flag,
  output logic o_original_source_flag,
  output logic o_preemphasis_flag,
  output logic o_opt_oe,
  output logic o_user_bit_out,
  output logic o_cs_bit_out,
  output logic o_master,
  output logic [1:0] o_format,
  output logic o_i2c_addr_bit,
  output logic o_running
);
  // ************************************************
  // pin synchronisers
  // ************************************************
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  assign pin_raw = {i_mode_hw, i_serial_audio_out_pin, i_original_source_flag_pin, i_preemphasis_flag_pin, i_bclk_pin, i_wclk_pin, i_pll_lock};
  always_ff @(posedge i_sys_clk) begin
    if (i_ce) begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end
  wire mode_hw_s = sync2_reg[6];
  wire serial_audio_out_s = sync2_reg[5];
  wire original_source_flag_s = sync2_reg[4];
  wire preemphasis_flag_s = sync2_reg[3];
  wire bclk_s = sync2_reg[2];
  wire wclk_s = sync2_reg[1];
  wire lock_s = sync2_reg[0];

  // ************************************************
  // start-up sequence
  // ************************************************
  rsp_pkg::rsp_state_t state_reg, state_next;
  logic [31:0] settle_cnt_reg;
  logic run_reg;
  logic opt_taken_reg;
  wire settle_done = settle_cnt_reg >= 32'(SETTLE_CYCLES - 1);
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rsp_pkg::ST_RESET: state_next = rsp_pkg::ST_IDLE;
      rsp_pkg::ST_IDLE: if (run_reg) state_next = rsp_pkg::ST_SETTLE;
      rsp_pkg::ST_SETTLE: begin
        if (!run_reg) state_next = rsp_pkg::ST_IDLE;
        else if (lock_s && settle_done) state_next = rsp_pkg::ST_RUN;
      end
      rsp_pkg::ST_RUN: if (!run_reg) state_next = rsp_pkg::ST_IDLE;
      default: state_next = rsp_pkg::ST_RESET;
    endcase
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_reg <= rsp_pkg::ST_RESET;
      settle_cnt_reg <= 32'h0000_0000;
    end else if (i_ce) begin
      state_reg <= state_next;
      if (state_reg == rsp_pkg::ST_SETTLE && lock_s && !settle_done) settle_cnt_reg <= settle_cnt_reg + 32'h1;
      else if (state_reg != rsp_pkg::ST_SETTLE || !lock_s) settle_cnt_reg <= 32'h0000_0000;
    end
  end
  wire active = state_reg == rsp_pkg::ST_RUN;

  // option pins sensed in the first cycle after release, then turned to outputs
  logic master_reg;
  logic [1:0] format_reg;
  logic i2c_bit_reg;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      opt_taken_reg <= 1'b0;
      master_reg <= 1'b0;
      format_reg <= 2'h0;
      i2c_bit_reg <= 1'b0;
    end else if (i_ce && !opt_taken_reg) begin
      opt_taken_reg <= 1'b1;
      i2c_bit_reg <= preemphasis_flag_s;
      if (mode_hw_s) begin
        master_reg <= serial_audio_out_s;
        format_reg <= {original_source_flag_s, preemphasis_flag_s};
      end
    end
  end

  // ************************************************
  // frame-rate status flags
  // ************************************************
  logic no_validity_error_out_reg;
  logic audio_reg;
  logic original_source_flag_reg;
  logic preemphasis_flag_reg;
  // general category (all zero) is never original; otherwise L bit marks original
  wire original_source_flag_decode = (i_cs_category != 8'h00) && i_cs_l_bit;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      no_validity_error_out_reg <= 1'b0;
      audio_reg <= 1'b0;
      original_source_flag_reg <= 1'b0;
      preemphasis_flag_reg <= 1'b1;
    end else if (i_ce && i_frame_stb) begin
      no_validity_error_out_reg <= i_parity_err | i_biphase_err | ~lock_s;
      audio_reg <= i_cs_audio;
      original_source_flag_reg <= original_source_flag_decode;
      preemphasis_flag_reg <= i_cs_preemphasis_flag != 3'h1;
    end
  end

  // ************************************************
  // serial audio port clocks and data
  // ************************************************
  logic [7:0] div_reg;
  logic bclk_gen_reg;
  logic [5:0] bitcnt_reg;
  logic wclk_gen_reg;
  logic bclk_d_reg;
  logic wclk_d_reg;
  logic [23:0] shift_reg;
  logic sdo_reg;
  wire div_wrap = div_reg == 8'(BCLK_DIV - 1);
  // master: falling edge of own bit clock; slave: falling edge of sampled bit clock
  wire bclk_fall = master_reg ? (div_wrap && bclk_gen_reg) : (bclk_d_reg && !bclk_s);
  wire wclk_cur = master_reg ? wclk_gen_reg : wclk_s;
  wire wclk_edge = master_reg ? (bclk_fall && bitcnt_reg == 6'(SLOT_BITS - 1)) : (wclk_d_reg != wclk_s);
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      div_reg <= 8'h00;
      bclk_gen_reg <= 1'b0;
      bitcnt_reg <= 6'h00;
      wclk_gen_reg <= 1'b0;
      bclk_d_reg <= 1'b0;
      wclk_d_reg <= 1'b0;
    end else if (i_ce) begin
      bclk_d_reg <= bclk_s;
      wclk_d_reg <= wclk_s;
      if (active && master_reg) begin
        div_reg <= div_wrap ? 8'h00 : div_reg + 8'h01;
        if (div_wrap) bclk_gen_reg <= ~bclk_gen_reg;
        if (bclk_fall) begin
          bitcnt_reg <= bitcnt_reg == 6'(SLOT_BITS - 1) ? 6'h00 : bitcnt_reg + 6'h01;
          if (bitcnt_reg == 6'(SLOT_BITS - 1)) wclk_gen_reg <= ~wclk_gen_reg;
        end
      end
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      shift_reg <= 24'h000000;
      sdo_reg <= 1'b0;
      o_user_bit_out <= 1'b0;
      o_cs_bit_out <= 1'b0;
    end else if (i_ce) begin
      if (!active) begin
        sdo_reg <= 1'b0;
      end else if (wclk_edge) begin
        shift_reg <= {i_sample[22:0], 1'b0};
        sdo_reg <= i_sample[23];
        o_user_bit_out <= i_user_bit;
        o_cs_bit_out <= i_cs_bit;
      end else if (bclk_fall) begin
        shift_reg <= {shift_reg[22:0], 1'b0};
        sdo_reg <= shift_reg[23];
      end
    end
  end

  // ************************************************
  // apb slave and interrupts
  // ************************************************
  logic [31:0] ctrl_reg;
  logic [rsp_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [rsp_pkg::IRQ_W-1:0] irq_en_reg;
  logic lock_d_reg;
  logic active_d_reg;
  wire apb_acc = i_psel && i_penable;
  wire apb_wr = apb_acc && o_pready && i_pwrite && !mode_hw_s;
  wire addr_ok = i_paddr == rsp_pkg::ADDR_CTRL || i_paddr == rsp_pkg::ADDR_STATUS ||
                 i_paddr == rsp_pkg::ADDR_IRQ_STAT || i_paddr == rsp_pkg::ADDR_IRQ_CLR ||
                 i_paddr == rsp_pkg::ADDR_IRQ_EN || i_paddr == rsp_pkg::ADDR_ID;
  wire [rsp_pkg::IRQ_W-1:0] irq_evt = {active && !active_d_reg, lock_d_reg && !lock_s,
                                      i_frame_stb && (i_parity_err || i_biphase_err || !lock_s)};
  wire [rsp_pkg::IRQ_W-1:0] irq_clr = (apb_wr && i_paddr == rsp_pkg::ADDR_IRQ_CLR) ?
                                      i_pwdata[rsp_pkg::IRQ_W-1:0] : 3'h0;
  logic [31:0] rd_mux;
  always_comb begin
    case (i_paddr)
      rsp_pkg::ADDR_CTRL: rd_mux = ctrl_reg;
      rsp_pkg::ADDR_STATUS: rd_mux = {24'h000000, audio_reg, original_source_flag_reg, preemphasis_flag_reg, no_validity_error_out_reg, lock_s, master_reg,
                                      mode_hw_s, active};
      rsp_pkg::ADDR_IRQ_STAT: rd_mux = {29'h0, irq_stat_reg};
      rsp_pkg::ADDR_IRQ_EN: rd_mux = {29'h0, irq_en_reg};
      rsp_pkg::ADDR_ID: rd_mux = {24'h000000, rsp_pkg::DEV_ID_CODE, rsp_pkg::REV_CODE};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      ctrl_reg <= rsp_pkg::CTRL_RST;
      run_reg <= 1'b0;
      irq_stat_reg <= rsp_pkg::IRQ_RST;
      irq_en_reg <= rsp_pkg::IRQ_RST;
      lock_d_reg <= 1'b0;
      active_d_reg <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_irq <= 1'b0;
    end else if (i_ce) begin
      lock_d_reg <= lock_s;
      active_d_reg <= active;
      // set wins over a clear in the same cycle
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_evt;
      if (apb_wr && i_paddr == rsp_pkg::ADDR_CTRL) begin
        ctrl_reg <= i_pwdata;
        run_reg <= i_pwdata[rsp_pkg::CTRL_RUN_BIT];
      end
      if (apb_wr && i_paddr == rsp_pkg::ADDR_IRQ_EN) irq_en_reg <= i_pwdata[rsp_pkg::IRQ_W-1:0];
      o_pready <= apb_acc && !o_pready;
      o_pslverr <= apb_acc && !o_pready && !addr_ok;
      o_prdata <= (apb_acc && !i_pwrite) ? rd_mux : 32'h0000_0000;
      o_irq <= |(irq_stat_reg & irq_en_reg);
    end
  end

  // ************************************************
  // output registers
  // ************************************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_no_validity_error_out <= 1'b0;
      o_serial_audio_out <= 1'b0;
      o_serial_audio_oe <= 1'b0;
      o_out_bit_clock <= 1'b0;
      o_out_bit_clock_oe <= 1'b0;
      o_out_word_clock <= 1'b0;
      o_out_word_clock_oe <= 1'b0;
      o_audio_flag <= 1'b0;
      o_original_source_flag <= 1'b0;
      o_preemphasis_flag <= 1'b0;
      o_opt_oe <= 1'b0;
      o_master <= 1'b0;
      o_format <= 2'h0;
      o_i2c_addr_bit <= 1'b0;
      o_running <= 1'b0;
    end else if (i_ce) begin
      o_no_validity_error_out <= no_validity_error_out_reg;
      o_serial_audio_out <= sdo_reg;
      o_serial_audio_oe <= opt_taken_reg;
      o_out_bit_clock <= bclk_gen_reg;
      o_out_bit_clock_oe <= active && master_reg;
      o_out_word_clock <= wclk_cur;
      o_out_word_clock_oe <= active && master_reg;
      o_audio_flag <= audio_reg;
      o_original_source_flag <= original_source_flag_reg;
      o_preemphasis_flag <= preemphasis_flag_reg;
      o_opt_oe <= opt_taken_reg;
      o_master <= master_reg;
      o_format <= format_reg;
      o_i2c_addr_bit <= i2c_bit_reg;
      o_running <= active;
    end
  end

  // ************************************************
  // assertions
  // ************************************************
  AST_NO_VALIDITY_ERROR_OUT_CAUSE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && i_frame_stb && (i_parity_err || i_biphase_err)) |=> no_validity_error_out_reg)
    else $error("error flag missed a frame error");
  AST_NO_VALIDITY_ERROR_OUT_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && !i_frame_stb) |=> $stable(no_validity_error_out_reg))
    else $error("error flag changed between frames");
  AST_OPT_ONCE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    opt_taken_reg |=> opt_taken_reg && $stable(master_reg) && $stable(format_reg))
    else $error("start-up options changed after capture");
  AST_NO_RUN_EARLY: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (state_reg == rsp_pkg::ST_RUN && $past(state_reg) != rsp_pkg::ST_RUN) |-> $past(lock_s))
    else $error("outputs enabled before lock");
  AST_IDLE_MUTE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && !active) |=> !sdo_reg)
    else $error("serial data not muted");
  AST_RUN_START: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && state_reg == rsp_pkg::ST_IDLE && run_reg) |=> state_reg == rsp_pkg::ST_SETTLE)
    else $error("run bit did not start settling");
  AST_PREEMPHASIS_FLAG: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && i_frame_stb) |=> preemphasis_flag_reg == ($past(i_cs_preemphasis_flag) != 3'h1))
    else $error("emphasis flag wrong");
  AST_ORIGINAL_SOURCE_FLAG: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && i_frame_stb && i_cs_category == 8'h00) |=> !original_source_flag_reg)
    else $error("general category flagged original");
  AST_CU_SHIFT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && active && wclk_edge) |=> o_user_bit_out == $past(i_user_bit))
    else $error("user bit not presented on word edge");
  AST_CLK_OE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (i_ce && !master_reg) |=> !o_out_bit_clock_oe && !o_out_word_clock_oe)
    else $error("slave drove output clocks");
  COV_RUN: cover property (@(posedge i_sys_clk) state_reg == rsp_pkg::ST_RUN);
  COV_NO_VALIDITY_ERROR_OUT: cover property (@(posedge i_sys_clk) o_no_validity_error_out);
  COV_IRQ: cover property (@(posedge i_sys_clk) o_irq);
endmodule

// [tb/rsp_partner.sv]
// downstream audio logic model: supplies the port clocks in the slave role, measures word length
// assumes the bench resolves each clock pin from the block's enable and this model's drive
`timescale 1ns/1ps
module rsp_partner (
  input wire logic i_en,
  input wire logic i_drive,
  input wire logic i_bclk,
  input wire logic i_wclk,
  output logic o_bclk,
  output logic o_wclk,
  output logic [7:0] o_bits
);
  logic [7:0] cnt;
  logic [5:0] slot;
  logic wl;
  initial begin
    o_bclk = 1'b0;
    o_wclk = 1'b0;
    o_bits = 8'h00;
    cnt = 8'h00;
    slot = 6'h00;
    wl = 1'b0;
  end
  // 160 ns bit clock, standing still outside a stream
  always begin
    #80;
    if (i_en && i_drive) begin
      o_bclk = ~o_bclk;
      if (!o_bclk) slot = slot + 6'h01;
      // one word-clock half per 32-bit slot: one period per sample pair
      if (!o_bclk && slot == 6'h20) begin
        slot = 6'h00;
        o_wclk = ~o_wclk;
      end
    end
  end
  // bit clocks counted between word-clock edges on the resolved pins
  always @(posedge i_bclk) begin
    if (i_wclk != wl) begin
      o_bits <= cnt;
      cnt <= 8'h01;
      wl <= i_wclk;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
endmodule

// [tb/tb_top.sv]
// self-checking bench for the receiver status-pin and start-up block
// assumes the block answers apb one cycle into the access phase; straps held by pulls
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0, rst_n = 1'b0, stb = 1'b0, perr = 1'b0, berr = 1'b0, lock = 1'b1;
  logic csb = 1'b0, ub = 1'b0, aud = 1'b0, lb = 1'b0, mode = 1'b1;
  logic [7:0] cat = 8'h00, paddr = 8'h00;
  logic [2:0] em = 3'h0;
  logic [23:0] smp = 24'h000000;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [31:0] pwd = 32'h00000000, rnd = 32'hE9522B17, prd;
  logic prdy, perr_o, irq, no_validity_error_out, sd, sd_oe, bo, bo_oe, wo, wo_oe, audf, origf, emf, opt_oe, uo, co, run;
  logic bclk, wclk, p_b, p_w;
  logic sd_pull = 1'b1, mst, i2c_b;
  logic [1:0] fmt;
  logic [7:0] bits;
  logic [31:0] exp_q[$];
  logic err_q[$];
  int fail_count = 0, tests_run = 0, cyc = 0, n;
  logic ex;
  assign bclk = bo_oe ? bo : p_b;
  assign wclk = wo_oe ? wo : p_w;
  always #2 clk = ~clk;
  rsp_top #(.SETTLE_CYCLES(8)) u_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_frame_stb(stb),
    .i_parity_err(perr), .i_biphase_err(berr), .i_pll_lock(lock), .i_cs_bit(csb), .i_user_bit(ub),
    .i_cs_audio(aud), .i_cs_l_bit(lb), .i_cs_category(cat), .i_cs_preemphasis_flag(em), .i_sample(smp), .i_mode_hw(mode),
    .i_serial_audio_out_pin(sd_oe ? sd : sd_pull), .i_original_source_flag_pin(opt_oe ? origf : 1'b0), .i_preemphasis_flag_pin(opt_oe ? emf : 1'b1),
    .i_bclk_pin(bclk), .i_wclk_pin(wclk), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr_o), .o_irq(irq),
    .o_no_validity_error_out(no_validity_error_out), .o_serial_audio_out(sd), .o_serial_audio_oe(sd_oe), .o_out_bit_clock(bo),
    .o_out_bit_clock_oe(bo_oe), .o_out_word_clock(wo), .o_out_word_clock_oe(wo_oe), .o_audio_flag(audf),
    .o_original_source_flag(origf), .o_preemphasis_flag(emf), .o_opt_oe(opt_oe), .o_user_bit_out(uo),
    .o_cs_bit_out(co), .o_master(mst), .o_format(fmt), .o_i2c_addr_bit(i2c_b), .o_running(run));
  rsp_partner u_partner (.i_en(run), .i_drive(~bo_oe), .i_bclk(bclk), .i_wclk(wclk), .o_bclk(p_b),
    .o_wclk(p_w), .o_bits(bits));
  // ************************************************
  // checking and closing
  // ************************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    if (fail_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      summarize();
    end
  end
  // completed transfers are compared against the oldest note
  always @(posedge clk) begin
    if (psel && pen && prdy === 1'b1 && err_q.size() > 0) begin
      if (!pwr) chk("prdata", prd, exp_q.pop_front());
      chk("pslverr", {31'h0, perr_o}, {31'h0, err_q.pop_front()});
    end
  end
  // ************************************************
  // stimulus
  // ************************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
    input logic er);
    n = 0;
    if (!w) exp_q.push_back(e);
    err_q.push_back(er);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1 && ++n < 50);
    if (n >= 50) fail_count++;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic frame(input logic p, input logic b, input logic [2:0] e, input logic [7:0] c);
    rnd = lfsr(rnd);
    perr <= p;
    berr <= b;
    em <= e;
    cat <= c;
    aud <= rnd[0];
    lb <= rnd[1];
    smp <= rnd[31:8];
    stb <= 1'b1;
    @(posedge clk);
    stb <= 1'b0;
    repeat (3) @(posedge clk);
    chk("no_validity_error_out", {31'h0, no_validity_error_out}, {31'h0, p | b | ~lock});
    chk("audio", {31'h0, audf}, {31'h0, rnd[0]});
    chk("original_source_flag", {31'h0, origf}, {31'h0, (c != 8'h00) & rnd[1]});
    chk("preemphasis_flag", {31'h0, emf}, {31'h0, e != 3'h1});
  endtask
  // ub/csb change two edges before the word-edge wait so the design never latches a stale bit
  task automatic cu_words();
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      ub <= rnd[0];
      csb <= rnd[1];
      repeat (2) @(posedge clk);
      ex = wclk;
      n = 0;
      while (wclk === ex && n < 3000) begin
        @(posedge clk);
        n++;
      end
      repeat (8) @(posedge clk);
      chk("user_bit", {31'h0, uo}, {31'h0, rnd[0]});
      chk("cs_bit", {31'h0, co}, {31'h0, rnd[1]});
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    chk("run_rst", {31'h0, run}, 32'h0);
    chk("optoe_rst", {31'h0, opt_oe | sd_oe | irq}, 32'h0);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk("opt_oe", {31'h0, opt_oe}, 32'h1);
    chk("addr_bit", {31'h0, i2c_b}, 32'h1);
    chk("master", {31'h0, mst}, 32'h1);
    chk("format", {30'h0, fmt}, 32'h1);
    apb(1'b1, rsp_pkg::ADDR_CTRL, 32'h1 << rsp_pkg::CTRL_RUN_BIT, 32'h0, 1'b0);
    mode <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b0, rsp_pkg::ADDR_ID, 32'h0, (32'(rsp_pkg::DEV_ID_CODE) << rsp_pkg::ID_DEV_LSB) |
      (32'(rsp_pkg::REV_CODE) << rsp_pkg::ID_REV_LSB), 1'b0);
    apb(1'b0, 8'hFC, 32'h0, 32'h0, 1'b1);
    apb(1'b0, rsp_pkg::ADDR_CTRL, 32'h0, rsp_pkg::CTRL_RST, 1'b0);
    apb(1'b1, rsp_pkg::ADDR_IRQ_EN, 32'h1 << rsp_pkg::IRQ_NO_VALIDITY_ERROR_OUT_BIT, 32'h0, 1'b0);
    chk("run_early", {31'h0, run}, 32'h0);
    apb(1'b1, rsp_pkg::ADDR_CTRL, 32'h1 << rsp_pkg::CTRL_RUN_BIT, 32'h0, 1'b0);
    n = 0;
    while (run !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk("running", {31'h0, run}, 32'h1);
    chk("clk_oe", {30'h0, bo_oe, wo_oe}, 32'h3);
    for (int i = 0; i < 8; i++) frame(i == 3, i == 5, 3'(i), (i == 2) ? 8'h00 : 8'(i + 1));
    chk("irq", {31'h0, irq}, 32'h1);
    apb(1'b0, rsp_pkg::ADDR_IRQ_STAT, 32'h0, (32'h1 << rsp_pkg::IRQ_NO_VALIDITY_ERROR_OUT_BIT) |
      (32'h1 << rsp_pkg::IRQ_OUTEN_BIT), 1'b0);
    apb(1'b1, rsp_pkg::ADDR_IRQ_CLR, 32'h1 << rsp_pkg::IRQ_NO_VALIDITY_ERROR_OUT_BIT, 32'h0, 1'b0);
    // the clear lands at the completing edge; the registered irq follows one edge later
    @(posedge clk);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    repeat (3000) @(posedge clk);
    chk("bits_per_word", {24'h0, bits}, 32'd32);
    cu_words();
    lock <= 1'b0;
    repeat (6) @(posedge clk);
    frame(1'b0, 1'b0, 3'h0, 8'h01);
    // second release with the data strap pulled low: slave port, clocks come from the partner
    rst_n <= 1'b0;
    lock <= 1'b1;
    mode <= 1'b1;
    sd_pull <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk("master_slv", {31'h0, mst}, 32'h0);
    mode <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b1, rsp_pkg::ADDR_CTRL, 32'h1 << rsp_pkg::CTRL_RUN_BIT, 32'h0, 1'b0);
    for (n = 0; run !== 1'b1 && n < 200; n++) @(posedge clk);
    chk("running_slv", {31'h0, run}, 32'h1);
    chk("clk_oe_slv", {30'h0, bo_oe, wo_oe}, 32'h0);
    cu_words();
    summarize();
  end
endmodule
